// ==== common/fhi_pkg.sv ====
// shared constants and carrier types of the framer interrupt status block
package fhi_pkg;

   // ------------------------------------------------------------
   // register word indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_HDLC_TX_STATUS = 10'h069;
   localparam logic [9:0] IDX_ALARM_STATUS   = 10'h06A;
   localparam logic [9:0] IDX_MASK_ONE       = 10'h06C;
   localparam logic [9:0] IDX_MASK_TWO       = 10'h06D;
   localparam logic [9:0] IDX_CONTROL        = 10'h06E;
   localparam logic [9:0] IDX_GLOBAL_SUMMARY = 10'h06F;
   localparam logic [9:0] IDX_LIVE_STATUS    = 10'h070;

   // ------------------------------------------------------------
   // bit positions of hdlc_tx_irq_status
   // ------------------------------------------------------------
   localparam int B1_CAS_EMPTY   = 7;
   localparam int B1_RX_OVERFLOW = 6;
   localparam int B1_ALL_SENT    = 5;
   localparam int B1_UNDERRUN    = 4;
   localparam int B1_MF_BEGIN    = 3;
   localparam int B1_SU_ERROR    = 2;
   localparam int B1_LINE_CHANGE = 1;
   localparam int B1_POOL_READY  = 0;

   // ------------------------------------------------------------
   // bit positions of alarm_irq_status
   // ------------------------------------------------------------
   localparam int B2_SYNC_REGAINED = 7;
   localparam int B2_SYNC_LOST     = 6;
   localparam int B2_MF_REGAINED   = 5;
   localparam int B2_MF_LOST       = 4;
   localparam int B2_BLUE_ALARM    = 3;
   localparam int B2_SIGNAL_ABSENT = 2;
   localparam int B2_DISTANT_CLEAR = 1;
   localparam int B2_DISTANT_ALARM = 0;

   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0] RST_STATUS    = 8'h00;
   localparam logic [7:0] RST_MASK      = 8'hFF;
   localparam logic [7:0] RST_THRESHOLD = 8'h10;
   localparam logic [4:0] FRAMES_PER_CAS = 5'd24;
   localparam logic [6:0] TX_BLOCK_BYTES = 7'd32;
   localparam int PCLK_MHZ          = 40;
   localparam int SU_REPEAT_TIME_US = 1000;
   localparam int SU_REPEAT_CYC_DEF = SU_REPEAT_TIME_US * PCLK_MHZ;

   // ------------------------------------------------------------
   // transmit multiframe formats
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FMT_EXT_SUPERFRAME = 2'b00,
      FMT_SUPERFRAME_12  = 2'b01,
      FMT_SUPERFRAME_72  = 2'b10
   } fhi_fmt_e;

   // control register, bits 6:0
   typedef struct packed {
      logic     signaling_system_seven;
      logic     hdlc_mode;
      logic     serial_sig_access;
      fhi_fmt_e frame_format;
      logic     any_change_irq_mode;
      logic     show_masked_status;
   } fhi_ctrl_s;

   // transmit and hdlc side events and levels
   typedef struct packed {
      logic       tx_frame_tick;
      logic       tx_mf_tick;
      logic       tx_last_bit;
      logic       tx_queue_empty;
      logic       tx_need_byte;
      logic       tx_message_end_cmd;
      logic [6:0] tx_queue_free;
      logic       rx_byte_valid;
      logic       rx_queue_full;
      logic [7:0] su_error_count;
      logic       su_valid_frame;
      logic       su_invalid_frame;
      logic       tx_line_open;
      logic       tx_line_short;
   } fhi_tx_in_s;

   // framer synchronisation and alarm levels
   typedef struct packed {
      logic frame_sync_lost;
      logic multiframe_sync_lost;
      logic blue_alarm;
      logic signal_absent_alarm;
      logic distant_alarm_status;
      logic alarm_sim;
   } fhi_alarm_in_s;

endpackage

// ==== rtl/fhi_irq_status.sv ====
// framer hdlc and alarm interrupt status registers with apb access
//
// Behaviour
// RL1 - reading a status register clears its bits
// RL2 - show-masked option still latches masked events
// RL3 - masked events never reach pin or summary
// RL4 - extended superframe: cas-empty at each multiframe start
// RL5 - 12/72-frame formats: cas-empty every 24 frames
// RL6 - serial signaling access suppresses cas-empty
// RL7 - overflow flagged when byte lost, queue full
// RL8 - receiver keeps storing once queue has room
// RL9 - all-sent on last bit, queue empty, hdlc
// RL10 - mid-frame empty without message end: abort, underrun
// RL11 - underrun holds transmitter off until status read
// RL12 - software should keep underrun unmasked
// RL13 - multiframe-begin at each transmit multiframe start
// RL14 - su error flag follows count versus threshold
// RL15 - invalid frames reissue su error periodically
// RL16 - line change on open rise, short change
// RL17 - pool ready when 32 bytes of room
// RL18 - sync regained/lost flags, including simulation end
// RL19 - 12/72-frame: multiframe regained/lost on transitions
// RL20 - blue/signal-absent on detection or any change
// RL21 - distant alarm rise, clear, simulation end
// RL22 - alarm status bit order 7 down to 0
// RL23 - event in clearing read cycle stays latched
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module fhi_irq_status
   import fhi_pkg::*;
#(
   parameter int SU_REPEAT_CYC = SU_REPEAT_CYC_DEF  // su error repeat period
)(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          ce,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire fhi_tx_in_s    tx_in,
   input  wire fhi_alarm_in_s alarm_in,
   output logic               irq_n,
   output logic               tx_abort,
   output logic               tx_hold,
   output logic               rx_store
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  isr_one;       // hdlc_tx_irq_status
      logic [7:0]  isr_two;       // alarm_irq_status
      logic [7:0]  mask_one;      // irq_mask_one
      logic [7:0]  mask_two;      // irq_mask_two
      fhi_ctrl_s   ctrl;          // mode and option bits
      logic [7:0]  su_threshold;  // su error threshold
      logic [31:0] rdata;         // captured read word
      logic        ack;           // access phase answered next edge
      logic        err;           // unmapped address seen
      logic        tx_hold;       // transmitter held after underrun
      logic        tx_abort;      // one-cycle abort request
      logic [4:0]  frame_cnt;     // frames since last cas-empty
      logic [15:0] rep_cnt;       // su error repeat timer
      logic        rep_active;    // invalid frames keep su error alive
      logic        p_open;        // previous line open
      logic        p_short;       // previous line short
      logic        p_room;        // previous pool room
      logic        p_over;        // previous su over threshold
      logic        p_fsync;       // previous frame sync lost
      logic        p_msync;       // previous multiframe sync lost
      logic        p_blue;        // previous blue alarm
      logic        p_absent;      // previous signal absent
      logic        p_dist;        // previous distant alarm
      logic        p_sim;         // previous alarm simulation
   } fhi_state_s;

   fhi_state_s r;       // registered state
   fhi_state_s next_r;  // next state

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // level went from low to high
   function automatic logic rise(input logic prev, input logic cur);
      return ~prev & cur;
   endfunction

   // level went from high to low
   function automatic logic fall(input logic prev, input logic cur);
      return prev & ~cur;
   endfunction

   // unmasked part of a status register
   function automatic logic live_any(input logic [7:0] st, input logic [7:0] m);
      return |(st & ~m);
   endfunction

   // ------------------------------------------------------------
   // combinational next state
   // ------------------------------------------------------------
   logic [7:0]  ev_one;     // hdlc/tx events this cycle
   logic [7:0]  ev_two;     // alarm events this cycle
   logic [7:0]  gate_one;   // latch enable per bit
   logic [7:0]  gate_two;   // latch enable per bit
   logic [7:0]  clr_one;    // bits cleared by completed read
   logic [7:0]  clr_two;    // bits cleared by completed read
   logic        access;     // apb access phase
   logic        done;       // access completes this edge
   logic [9:0]  idx;        // word index
   logic        mapped;     // index decodes to a register
   logic [31:0] rd_word;    // read mux
   logic        su_over;    // su error count over threshold
   logic        room;       // tx queue can take a block
   logic        underrun;   // tx queue ran dry mid frame
   logic        sim_end;    // alarm simulation just ended
   logic        multi_fmt;  // 12- or 72-frame format selected
   logic        cas_tick;   // cas-empty event before suppression
   logic        rep_fire;   // su error repeat timer expired

   always_comb begin
      next_r   = r;
      idx      = paddr[11:2];
      access   = psel & penable;
      done     = access & r.ack;
      mapped   = 1'b1;
      rd_word  = 32'h0000_0000;
      ev_one   = 8'h00;
      ev_two   = 8'h00;
      clr_one  = 8'h00;
      clr_two  = 8'h00;
      next_r.tx_abort = 1'b0;

      // read decode
      case (idx)
         IDX_HDLC_TX_STATUS: rd_word[7:0] = r.isr_one;
         IDX_ALARM_STATUS:   rd_word[7:0] = r.isr_two;
         IDX_MASK_ONE:       rd_word[7:0] = r.mask_one;
         IDX_MASK_TWO:       rd_word[7:0] = r.mask_two;
         IDX_CONTROL: begin
            rd_word[6:0]  = r.ctrl;
            rd_word[15:8] = r.su_threshold;
         end
         IDX_GLOBAL_SUMMARY: begin
            rd_word[0] = live_any(r.isr_one, r.mask_one);  // [RL3]
            rd_word[1] = live_any(r.isr_two, r.mask_two);  // [RL3]
         end
         IDX_LIVE_STATUS: begin
            rd_word[0] = tx_in.tx_line_open;
            rd_word[1] = tx_in.tx_line_short;
            rd_word[2] = r.tx_hold;
            rd_word[3] = r.p_over;
         end
         default: mapped = 1'b0;
      endcase

      // first access cycle captures the answer, second completes
      if (access && !r.ack) begin
         next_r.ack   = 1'b1;
         next_r.rdata = pwrite ? 32'h0000_0000 : rd_word;
         next_r.err   = ~mapped;
      end else begin
         next_r.ack = 1'b0;
      end

      // writes take effect at completion
      if (done && pwrite && mapped) begin
         case (idx)
            IDX_MASK_ONE: next_r.mask_one = pwdata[7:0];
            IDX_MASK_TWO: next_r.mask_two = pwdata[7:0];
            IDX_CONTROL: begin
               next_r.ctrl         = fhi_ctrl_s'(pwdata[6:0]);
               next_r.su_threshold = pwdata[15:8];
            end
            default: next_r.ctrl = r.ctrl;
         endcase
      end

      // read clears exactly the bits that were reported
      if (done && !pwrite && idx == IDX_HDLC_TX_STATUS) begin
         clr_one = r.rdata[7:0];  // [RL1]
      end
      if (done && !pwrite && idx == IDX_ALARM_STATUS) begin
         clr_two = r.rdata[7:0];  // [RL1]
      end

      // ---------------- transmit multiframe and cas ----------------
      multi_fmt = (r.ctrl.frame_format == FMT_SUPERFRAME_12) ||
                  (r.ctrl.frame_format == FMT_SUPERFRAME_72);
      cas_tick  = 1'b0;
      if (multi_fmt) begin
         if (tx_in.tx_frame_tick) begin
            if (r.frame_cnt == FRAMES_PER_CAS - 5'd1) begin
               next_r.frame_cnt = 5'd0;
               cas_tick         = 1'b1;  // [RL5]
            end else begin
               next_r.frame_cnt = r.frame_cnt + 5'd1;
            end
         end
      end else begin
         next_r.frame_cnt = 5'd0;
         cas_tick = (r.ctrl.frame_format == FMT_EXT_SUPERFRAME) &
                    tx_in.tx_mf_tick;  // [RL4]
      end
      ev_one[B1_CAS_EMPTY] = cas_tick & ~r.ctrl.serial_sig_access;  // [RL6]
      ev_one[B1_MF_BEGIN]  = tx_in.tx_mf_tick;  // [RL13]

      // ---------------- hdlc receive and transmit ----------------
      ev_one[B1_RX_OVERFLOW] = tx_in.rx_byte_valid & tx_in.rx_queue_full;  // [RL7]
      ev_one[B1_ALL_SENT] = r.ctrl.hdlc_mode & tx_in.tx_last_bit &
                            tx_in.tx_queue_empty;  // [RL9]
      underrun = tx_in.tx_need_byte & tx_in.tx_queue_empty &
                 ~tx_in.tx_message_end_cmd & ~r.tx_hold;
      ev_one[B1_UNDERRUN] = underrun;  // [RL10]
      if (underrun) begin
         next_r.tx_abort = 1'b1;  // [RL10]
         next_r.tx_hold  = 1'b1;  // [RL11]
      end else if (clr_one[B1_UNDERRUN]) begin
         next_r.tx_hold  = 1'b0;  // [RL11]
      end
      room = tx_in.tx_queue_free >= TX_BLOCK_BYTES;
      next_r.p_room = room;
      ev_one[B1_POOL_READY] = rise(r.p_room, room);  // [RL17]

      // ---------------- signaling unit errors ----------------
      su_over = r.ctrl.signaling_system_seven & (tx_in.su_error_count > r.su_threshold);
      next_r.p_over = su_over;
      rep_fire = 1'b0;
      if (!su_over || tx_in.su_valid_frame) begin
         next_r.rep_active = 1'b0;  // [RL15]
         next_r.rep_cnt    = 16'd0;
      end else if (tx_in.su_invalid_frame && !r.rep_active) begin
         next_r.rep_active = 1'b1;
         next_r.rep_cnt    = 16'd0;
      end else if (r.rep_active) begin
         if (r.rep_cnt == 16'(SU_REPEAT_CYC - 1)) begin
            next_r.rep_cnt = 16'd0;
            rep_fire       = 1'b1;  // [RL15]
         end else begin
            next_r.rep_cnt = r.rep_cnt + 16'd1;
         end
      end
      ev_one[B1_SU_ERROR] = rise(r.p_over, su_over) | rep_fire;  // [RL14]

      // ---------------- transmit line monitor ----------------
      next_r.p_open  = tx_in.tx_line_open;
      next_r.p_short = tx_in.tx_line_short;
      ev_one[B1_LINE_CHANGE] = rise(r.p_open, tx_in.tx_line_open) |
                               (r.p_short ^ tx_in.tx_line_short);  // [RL16]

      // ---------------- framer alarms ----------------
      next_r.p_fsync  = alarm_in.frame_sync_lost;
      next_r.p_msync  = alarm_in.multiframe_sync_lost;
      next_r.p_blue   = alarm_in.blue_alarm;
      next_r.p_absent = alarm_in.signal_absent_alarm;
      next_r.p_dist   = alarm_in.distant_alarm_status;
      next_r.p_sim    = alarm_in.alarm_sim;
      sim_end = fall(r.p_sim, alarm_in.alarm_sim);

      ev_two[B2_SYNC_REGAINED] = fall(r.p_fsync, alarm_in.frame_sync_lost) |
         (sim_end & ~alarm_in.frame_sync_lost);  // [RL18]
      ev_two[B2_SYNC_LOST] = rise(r.p_fsync, alarm_in.frame_sync_lost) |
         alarm_in.alarm_sim;  // [RL18]
      ev_two[B2_MF_REGAINED] = (multi_fmt &
         fall(r.p_msync, alarm_in.multiframe_sync_lost)) |
         alarm_in.alarm_sim;  // [RL19]
      ev_two[B2_MF_LOST] = (multi_fmt &
         rise(r.p_msync, alarm_in.multiframe_sync_lost)) |
         alarm_in.alarm_sim;  // [RL19]
      if (r.ctrl.any_change_irq_mode) begin
         ev_two[B2_BLUE_ALARM]    = r.p_blue ^ alarm_in.blue_alarm;  // [RL20]
         ev_two[B2_SIGNAL_ABSENT] = r.p_absent ^ alarm_in.signal_absent_alarm;  // [RL20]
      end else begin
         ev_two[B2_BLUE_ALARM]    = rise(r.p_blue, alarm_in.blue_alarm);  // [RL20]
         ev_two[B2_SIGNAL_ABSENT] = rise(r.p_absent, alarm_in.signal_absent_alarm);  // [RL20]
      end
      ev_two[B2_BLUE_ALARM]    = ev_two[B2_BLUE_ALARM] | alarm_in.alarm_sim;
      ev_two[B2_SIGNAL_ABSENT] = ev_two[B2_SIGNAL_ABSENT] | alarm_in.alarm_sim;
      ev_two[B2_DISTANT_CLEAR] = fall(r.p_dist, alarm_in.distant_alarm_status) |
         (sim_end & ~alarm_in.distant_alarm_status);  // [RL21]
      ev_two[B2_DISTANT_ALARM] = rise(r.p_dist, alarm_in.distant_alarm_status) |
         alarm_in.alarm_sim;  // [RL21]

      // ---------------- latch with mask and visibility ----------------
      gate_one = r.ctrl.show_masked_status ? 8'hFF : ~r.mask_one;  // [RL2]
      gate_two = r.ctrl.show_masked_status ? 8'hFF : ~r.mask_two;  // [RL2]
      // set wins over a clearing read in the same cycle
      next_r.isr_one = (r.isr_one & ~clr_one) | (ev_one & gate_one);  // [RL23]
      next_r.isr_two = (r.isr_two & ~clr_two) | (ev_two & gate_two);  // [RL22] [RL23]
      // su error bit drops while the count is back under threshold
      if (!su_over && !ev_one[B1_SU_ERROR]) begin
         next_r.isr_one[B1_SU_ERROR] = 1'b0;  // [RL14]
      end
   end

   // ------------------------------------------------------------
   // state register, frozen while ce is low
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r              <= '0;
         r.isr_one      <= RST_STATUS;
         r.isr_two      <= RST_STATUS;
         r.mask_one     <= RST_MASK;
         r.mask_two     <= RST_MASK;
         r.su_threshold <= RST_THRESHOLD;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata   = r.rdata;
   assign pready   = r.ack & ce;
   assign pslverr  = r.ack & r.err & ce;
   // masked bits never drive the pin
   assign irq_n    = ~(live_any(r.isr_one, r.mask_one) |
                       live_any(r.isr_two, r.mask_two));  // [RL3]
   assign tx_abort = r.tx_abort;
   assign tx_hold  = r.tx_hold;  // [RL11]
   // bytes go on into the queue whenever it has room again
   assign rx_store = tx_in.rx_byte_valid & ~tx_in.rx_queue_full;  // [RL8]

endmodule // fhi_irq_status

`default_nettype wire

// ==== testbench/fhi_irq_status_chk.sv ====
// assertion checker for the framer interrupt status block
`timescale 1ns/1ps
`default_nettype none

module fhi_irq_status_chk
   import fhi_pkg::*;
#(
   parameter int SU_REPEAT_CYC = 8  // su error repeat period
)(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          ce,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire fhi_tx_in_s    tx_in,
   input wire fhi_alarm_in_s alarm_in,
   input wire logic          irq_n,
   input wire logic          tx_abort,
   input wire logic          tx_hold,
   input wire logic          rx_store
);
   // ----------
   // helper terms
   // ----------
   logic under;    // underrun condition at the inputs
   logic rd_done;  // completing read of the hdlc status
   assign under   = ce && tx_in.tx_need_byte && tx_in.tx_queue_empty
                    && !tx_in.tx_message_end_cmd;
   assign rd_done = psel && penable && pready && !pwrite
                    && paddr[11:2] == IDX_HDLC_TX_STATUS;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------
   // properties
   // ----------
   property p_rx_store; rx_store == (tx_in.rx_byte_valid && !tx_in.rx_queue_full); endproperty
   a_rx_store: assert property (p_rx_store)
      else $error("bad receive store");
   property p_abort; under && !tx_hold |=> tx_abort && tx_hold; endproperty
   a_abort: assert property (p_abort)
      else $error("underrun not handled");
   property p_abort_pulse; tx_abort && ce |=> !tx_abort; endproperty
   a_abort_pulse: assert property (p_abort_pulse)
      else $error("abort longer than one cycle");
   property p_abort_cause; $rose(tx_abort) |-> $past(under); endproperty
   a_abort_cause: assert property (p_abort_cause)
      else $error("abort without an underrun");
   property p_hold_set; $rose(tx_hold) |-> tx_abort; endproperty
   a_hold_set: assert property (p_hold_set)
      else $error("hold rose without an abort");
   property p_hold_keep; tx_hold && !rd_done |=> tx_hold; endproperty
   a_hold_keep: assert property (p_hold_keep)
      else $error("hold dropped early");
   property p_hold_free; $fell(tx_hold) |-> $past(rd_done); endproperty
   a_hold_free: assert property (p_hold_free)
      else $error("hold freed without read");
   property p_pready; psel && $rose(penable) && ce |-> !pready ##1 (pready || !ce); endproperty
   a_pready: assert property (p_pready)
      else $error("access phase not two cycles");
endmodule // fhi_irq_status_chk

bind fhi_irq_status fhi_irq_status_chk #(.SU_REPEAT_CYC(SU_REPEAT_CYC)) u_chk (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .tx_in(tx_in), .alarm_in(alarm_in), .irq_n(irq_n),
   .tx_abort(tx_abort), .tx_hold(tx_hold), .rx_store(rx_store)
);
`default_nettype wire

// ==== testbench/test_fhi_irq_status.sv ====
// self-checking bench of the framer interrupt status block
`timescale 1ns/1ps
`default_nettype none

module test_fhi_irq_status
   import fhi_pkg::*;
;
   // ----------
   // signals
   // ----------
   logic          pclk;            // bus clock
   logic          presetn;         // async reset
   logic          ce;              // clock enable
   logic          psel;            // apb select
   logic          penable;         // apb enable
   logic          pwrite;          // apb direction
   logic [11:0]   paddr;           // apb byte address
   logic [31:0]   pwdata;          // apb write data
   logic [31:0]   prdata;          // apb read data
   logic          pready;          // apb ready
   logic          pslverr;         // apb error
   fhi_tx_in_s    tx_in;           // transmit side events
   fhi_alarm_in_s alarm_in;        // alarm levels
   logic          irq_n;           // interrupt pin
   logic          tx_abort;        // abort pulse
   logic          tx_hold;         // transmitter held off
   logic          rx_store;        // receive byte stored
   logic [26:0]   ti = '0;         // idle transmit levels
   logic          msk = 1'b0;      // events masked
   logic          se;              // last slave error
   logic [31:0]   rv;              // last read value
   int            fail_count = 0;  // mismatches
   int            n_tests = 0;     // comparisons
   int            cyc = 0;         // cycles run
   // transmit event table and expected hdlc status
   logic [26:0]   tv [8] = '{27'h2000000, 27'h1800000, 27'h0003000, 27'h0C00000,
                             27'h0E00000, 27'h0000002, 27'h0000001, 27'h0080000};
   logic [7:0]    te [8] = '{8'h88, 8'h20, 8'h40, 8'h10, 8'h00, 8'h02, 8'h02, 8'h01};
   // alarm event table and expected alarm status
   logic [5:0]    av [5] = '{6'h20, 6'h04, 6'h02, 6'h01, 6'h10};
   logic [7:0]    ae [5] = '{8'hC0, 8'h04, 8'h03, 8'hFF, 8'h00};

   fhi_irq_status #(.SU_REPEAT_CYC(8)) u_dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_in(tx_in), .alarm_in(alarm_in), .irq_n(irq_n),
      .tx_abort(tx_abort), .tx_hold(tx_hold), .rx_store(rx_store));

   // ----------
   // clock, hang guard, closing report
   // ----------
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // hang guard, far above the few hundred cycles needed
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------
   // compare and bus tasks
   // ----------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {i, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] i, input logic [31:0] e);
      apb(1'b0, i, 32'h0);
      chk(rv, e);
   endtask
   // one-cycle transmit pulse over the idle levels
   task automatic drv(input logic [26:0] t);
      @(posedge pclk);
      tx_in <= fhi_tx_in_s'(t);
      @(posedge pclk);
      tx_in <= fhi_tx_in_s'(ti);
   endtask
   // event pulse, then pin, summary, status and clear checks
   task automatic ev(input logic s, input logic [26:0] t, input logic [5:0] a,
                     input logic [7:0] e);
      alarm_in <= fhi_alarm_in_s'(a);
      drv(t);
      alarm_in <= '0;
      repeat (2) @(posedge pclk);
      chk(irq_n, (e == 8'h00 || msk));
      rd(IDX_GLOBAL_SUMMARY, (e == 8'h00 || msk) ? 0 : (s ? 2 : 1));
      rd(s ? IDX_ALARM_STATUS : IDX_HDLC_TX_STATUS, e);
      rd(s ? IDX_ALARM_STATUS : IDX_HDLC_TX_STATUS, 0);
      chk(tx_hold, 1'b0);
   endtask
   // ----------
   // main sequence
   // ----------
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      tx_in = '0;
      alarm_in = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_HDLC_TX_STATUS, 0);
      rd(IDX_ALARM_STATUS, 0);
      rd(IDX_MASK_ONE, 32'hFF);
      rd(IDX_MASK_TWO, 32'hFF);
      rd(IDX_CONTROL, 32'h1000);
      rd(10'h06B, 0);
      chk(se, 1'b1);
      apb(1'b1, IDX_GLOBAL_SUMMARY, 32'hFF);
      rd(IDX_GLOBAL_SUMMARY, 0);
      apb(1'b1, IDX_MASK_ONE, 32'h0);
      apb(1'b1, IDX_MASK_TWO, 32'h0);
      apb(1'b1, IDX_CONTROL, 32'h1020);
      for (int k = 0; k < 8; k++)
         ev(1'b0, tv[k], 6'h0, te[k]);
      for (int k = 0; k < 5; k++) ev(1'b1, ti, av[k], ae[k]);
      // event landing during a clearing read must survive it
      fork
         rd(IDX_ALARM_STATUS, 0);
         begin
            repeat (2) @(posedge pclk);
            alarm_in <= fhi_alarm_in_s'(6'h02);
            @(posedge pclk);
            alarm_in <= '0;
         end
      join
      rd(IDX_ALARM_STATUS, 8'h03);
      // blue alarm fall counts only in any-change mode
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, IDX_CONTROL, 32'h1020 | (m << 1));
         alarm_in <= fhi_alarm_in_s'(6'h08);
         repeat (2) @(posedge pclk);
         rd(IDX_ALARM_STATUS, 8'h08);
         ev(1'b1, ti, 6'h08, m ? 8'h08 : 8'h00);
      end
      // masked events, without and with the show option
      apb(1'b1, IDX_MASK_ONE, 32'hFF);
      msk = 1'b1;
      ev(1'b0, 27'h2000000, 6'h0, 8'h00);
      apb(1'b1, IDX_CONTROL, 32'h1021);
      ev(1'b0, 27'h2000000, 6'h0, 8'h88);
      msk = 1'b0;
      apb(1'b1, IDX_MASK_ONE, 32'h0);
      // twelve-frame format: slot empty every 24th frame
      apb(1'b1, IDX_CONTROL, 32'h1004);
      repeat (23) drv(27'h4000000);
      rd(IDX_HDLC_TX_STATUS, 0);
      ev(1'b0, 27'h4000000, 6'h0, 8'h80);
      ev(1'b0, 27'h2000000, 6'h0, 8'h08);
      ev(1'b1, ti, 6'h10, 8'h30);
      ev(1'b0, 27'h1800000, 6'h0, 8'h00);
      apb(1'b1, IDX_CONTROL, 32'h1014);
      repeat (24) drv(27'h4000000);
      rd(IDX_HDLC_TX_STATUS, 0);
      // signaling unit errors above a threshold of 0x10
      apb(1'b1, IDX_CONTROL, 32'h1040);
      ti = 27'h110;
      ev(1'b0, 27'h110, 6'h0, 8'h04);
      drv(27'h114);
      repeat (12) @(posedge pclk);
      rd(IDX_HDLC_TX_STATUS, 8'h04);
      drv(27'h118);
      apb(1'b0, IDX_HDLC_TX_STATUS, 32'h0);
      repeat (20) @(posedge pclk);
      rd(IDX_HDLC_TX_STATUS, 0);
      ti = 27'h050;
      drv(27'h110);
      repeat (2) @(posedge pclk);
      rd(IDX_HDLC_TX_STATUS, 0);
      stop_test();
   end
endmodule // test_fhi_irq_status
`default_nettype wire
